// ===== vdli_pkg.sv
// Purpose: constants shared by the vertical-blanking data line inserter
// Assumes: 20 MHz pixel-rate clock, line numbers counted per frame
// Notes:   times are kept in ns and turned into clock counts here
package vdli_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 20;
  localparam int CC_BIT_NS      = 1986;   // caption bit period
  localparam int CG_BIT_NS      = 2235;   // copy-generation bit period
  localparam int WS_ELEM_NS     = 200;    // wide-screen element period
  localparam int CC_START_NS    = 10500;  // caption run-in start after line start
  localparam int CG_START_NS    = 11200;
  localparam int WS_START_NS    = 11000;
  localparam int WS_VIDEO_NS    = 42500;  // normal video from here on
  localparam int CC_BIT_CYC     = (CC_BIT_NS * CLK_MHZ) / 1000;
  localparam int CG_BIT_CYC     = (CG_BIT_NS * CLK_MHZ) / 1000;
  localparam int WS_ELEM_CYC    = (WS_ELEM_NS * CLK_MHZ) / 1000;
  localparam int CC_START_CYC   = (CC_START_NS * CLK_MHZ + 999) / 1000;
  localparam int CG_START_CYC   = (CG_START_NS * CLK_MHZ + 999) / 1000;
  localparam int WS_START_CYC   = (WS_START_NS * CLK_MHZ + 999) / 1000;
  localparam int WS_VIDEO_CYC   = (WS_VIDEO_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // line plan
  // ----------------------------------------------------------------
  localparam logic [9:0] CC_LINE_ODD  = 10'h015;  // 21
  localparam logic [9:0] CC_LINE_EVEN = 10'h11c;  // 284
  localparam logic [9:0] CG_LINE_ODD  = 10'h014;  // 20
  localparam logic [9:0] CG_LINE_EVEN = 10'h11b;  // 283
  localparam logic [9:0] WS_LINE      = 10'h017;  // 23
  localparam int CC_RUNIN_CYCLES = 7;
  localparam int CC_GAP_BITS     = 2;
  localparam int CC_NBITS        = 17;   // start bit + two bytes
  localparam int CG_NBITS        = 21;   // reference pulse + 20 bits
  localparam int WS_NBITS        = 81;   // run-in + start code + 28 elements
  localparam int SH_W            = 96;
  localparam logic [28:0] WS_RUNIN = 29'h1f1c71c7;
  localparam logic [23:0] WS_START = 24'h1e3c1f;
  localparam logic [5:0]  CRC_PRESET = 6'h3f;

  // ----------------------------------------------------------------
  // levels
  // ----------------------------------------------------------------
  localparam logic [9:0] LVL_BLANK = 10'h0f0;
  localparam logic [9:0] LVL_HIGH  = 10'h2a0;

  // ----------------------------------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CC0  = 8'h00;
  localparam logic [7:0] A_CC1  = 8'h04;
  localparam logic [7:0] A_CCX0 = 8'h08;
  localparam logic [7:0] A_CCX1 = 8'h0c;
  localparam logic [7:0] A_CW0  = 8'h10;
  localparam logic [7:0] A_CW1  = 8'h14;
  localparam logic [7:0] A_CW2  = 8'h18;
  localparam logic [7:0] A_CTRL = 8'h1c;
  localparam logic [7:0] A_STAT = 8'h20;
  localparam int F_CRC_AUTO = 4;
  localparam int F_CG_EN_A  = 5;
  localparam int F_CG_EN_B  = 6;
  localparam int F_WS_EN    = 7;
  localparam int F_CC_EN_ODD  = 0;
  localparam int F_CC_EN_EVEN = 1;
  localparam int F_STD_PAL    = 2;

  typedef enum logic [1:0] {K_NONE, K_CC, K_CG, K_WS} vdli_kind_e;

endpackage : vdli_pkg

// ===== vdli_inserter.sv
// Purpose: serialises caption, copy-generation and wide-screen data onto
//          the luma/composite line during vertical blanking
// Assumes: line_start pulses once per line at the sync falling edge and
//          line_num/field_even are valid in that cycle
// Notes:   payload is sampled at line_start; host writes later in the line
//          only affect the next insertion
`timescale 1ns/1ps
`default_nettype none

// Operation
// - caption goes on line 21 odd field and line 284 even field
// - each caption line opens with a seven-cycle sine run-in at bit rate
// - after run-in, blank for two bit periods, then a start bit of one
// - then sixteen bits: two caption bytes sent as written, parity left to the host
// - line 284 uses the separate extended caption byte pair
// - block makes all caption timing and ignores pixels on caption lines
// - single-buffered caption bytes go out on the next caption line
// - copy-generation data goes on line 20 odd and line 283 even
// - separate odd/even enables gate copy-generation, NTSC only
// - copy word is 20 bits after a one-bit reference pulse
// - reg0 bits 0-3 give bits 16-19, reg1 bits 8-15, reg2 bits 0-7
// - auto check computes bits 14-19 from 0-13, x^6+x+1, preset ones
// - without auto check all 20 register bits go out unchanged
// - copy payload is six-bit word, four-bit word, four-bit word, six-bit check
// - wide-screen data goes on line 23 only
// - wide-screen output only in PAL
// - wide-screen word of 14 bits after run-in and start code
// - reg2 gives wide-screen bits 0-7, reg1 bits 0-5 give bits 8-13
// - wide-screen needs its enable; normal video from 42.5 us onward
module vdli_inserter (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // line and field timing from the encoder
  input  wire logic       line_start,
  input  wire logic [9:0] line_num,
  input  wire logic       field_even,
  // video path
  input  wire logic [9:0] video_in,
  output var  logic [9:0] video_out,
  output logic            insert_active,
  // register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output var  logic [7:0] rdata
);

  typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_RUNIN, ST_GAP, ST_SHIFT} vdli_state_e;

  localparam int A_LONG = 700;   // bound on start delay seen by checks

  // ----------------------------------------------------------------
  // check-bit generator
  // ----------------------------------------------------------------
  // serial x^6+x+1 over bits 0..13, sent order, register preset to ones
  function automatic logic [5:0] vdli_crc(input logic [13:0] d);
    logic [5:0] c;
    logic       fb;
    c = vdli_pkg::CRC_PRESET;
    for (int i = 0; i < 14; i++) begin
      fb = c[5] ^ d[i];
      c  = {c[4:0], 1'b0} ^ {4'h0, fb, fb};
    end
    return c;
  endfunction : vdli_crc

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] cc0_reg, cc1_reg, ccx0_reg, ccx1_reg;
  logic [7:0] cw0_reg, cw1_reg, cw2_reg, ctrl_reg;
  vdli_state_e state_reg;
  vdli_pkg::vdli_kind_e kind_reg, kind_next;
  logic [vdli_pkg::SH_W-1:0] sh_reg, sh_next;
  logic [6:0]  nbits_reg, nbits_next;
  logic [10:0] cnt_reg;      // clocks within the current run-in cycle or bit
  logic [10:0] line_cnt_reg; // clocks since line start, saturating
  logic [10:0] period_reg, period_next;
  logic [3:0]  step_reg;     // run-in cycles or gap bits done
  logic [19:0] cg_word;
  logic [13:0] ws_word;      // wide-screen bits 0..13 in send order

  // reg2 gives bits 0-7, reg1 bits 0-5 give bits 8-13
  assign ws_word = {cw1_reg[5:0], cw2_reg};

  wire std_pal = ctrl_reg[vdli_pkg::F_STD_PAL];

  // host writes; single byte deep, no shadow, so next line sees it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cc0_reg  <= 8'h00;
      cc1_reg  <= 8'h00;
      ccx0_reg <= 8'h00;
      ccx1_reg <= 8'h00;
      cw0_reg  <= 8'h00;
      cw1_reg  <= 8'h00;
      cw2_reg  <= 8'h00;
      ctrl_reg <= 8'h00;
    end else if (wr) begin
      unique case (addr)
        vdli_pkg::A_CC0:  cc0_reg  <= wdata;
        vdli_pkg::A_CC1:  cc1_reg  <= wdata;
        vdli_pkg::A_CCX0: ccx0_reg <= wdata;
        vdli_pkg::A_CCX1: ccx1_reg <= wdata;
        vdli_pkg::A_CW0:  cw0_reg  <= wdata;
        vdli_pkg::A_CW1:  cw1_reg  <= wdata;
        vdli_pkg::A_CW2:  cw2_reg  <= wdata;
        vdli_pkg::A_CTRL: ctrl_reg <= wdata;
        default:          ;
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        vdli_pkg::A_CC0:  rdata <= cc0_reg;
        vdli_pkg::A_CC1:  rdata <= cc1_reg;
        vdli_pkg::A_CCX0: rdata <= ccx0_reg;
        vdli_pkg::A_CCX1: rdata <= ccx1_reg;
        vdli_pkg::A_CW0:  rdata <= cw0_reg;
        vdli_pkg::A_CW1:  rdata <= cw1_reg;
        vdli_pkg::A_CW2:  rdata <= cw2_reg;
        vdli_pkg::A_CTRL: rdata <= ctrl_reg;
        vdli_pkg::A_STAT: rdata <= {4'h0, insert_active, 1'b0, kind_reg};
        default:          rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // line classification and payload capture
  // ----------------------------------------------------------------
  // copy word: reg0[3:0]=16..19, reg1=8..15, reg2=0..7
  // word0 bits 0-5, word1 bits 6-9, check bits 14-19
  always_comb begin
    cg_word = {cw0_reg[3:0], cw1_reg, cw2_reg};
    if (cw0_reg[vdli_pkg::F_CRC_AUTO]) begin
      cg_word[19:14] = vdli_crc(cg_word[13:0]);
    end
  end

  // chooses what to send this line and snapshots its payload
  always_comb begin
    kind_next   = vdli_pkg::K_NONE;
    sh_next     = '0;
    nbits_next  = 7'h00;
    period_next = 11'h000;
    if (!std_pal && !field_even && line_num == vdli_pkg::CC_LINE_ODD &&
        ctrl_reg[vdli_pkg::F_CC_EN_ODD]) begin
      kind_next   = vdli_pkg::K_CC;
      sh_next     = {{(vdli_pkg::SH_W-17){1'b0}}, cc1_reg, cc0_reg, 1'b1};
      nbits_next  = 7'(vdli_pkg::CC_NBITS);
      period_next = 11'(vdli_pkg::CC_BIT_CYC);
    end else if (!std_pal && field_even && line_num == vdli_pkg::CC_LINE_EVEN &&
                 ctrl_reg[vdli_pkg::F_CC_EN_EVEN]) begin
      kind_next   = vdli_pkg::K_CC;
      sh_next     = {{(vdli_pkg::SH_W-17){1'b0}}, ccx1_reg, ccx0_reg, 1'b1};
      nbits_next  = 7'(vdli_pkg::CC_NBITS);
      period_next = 11'(vdli_pkg::CC_BIT_CYC);
    end else if (!std_pal &&
                 ((!field_even && line_num == vdli_pkg::CG_LINE_ODD &&
                   cw0_reg[vdli_pkg::F_CG_EN_A]) ||
                  (field_even && line_num == vdli_pkg::CG_LINE_EVEN &&
                   cw0_reg[vdli_pkg::F_CG_EN_B]))) begin
      kind_next   = vdli_pkg::K_CG;
      // reference pulse first, then bits 0..19 unchanged unless auto
      sh_next     = {{(vdli_pkg::SH_W-21){1'b0}}, cg_word, 1'b1};
      nbits_next  = 7'(vdli_pkg::CG_NBITS);
      period_next = 11'(vdli_pkg::CG_BIT_CYC);
    end else if (std_pal && line_num == vdli_pkg::WS_LINE &&
                 cw0_reg[vdli_pkg::F_WS_EN]) begin
      kind_next   = vdli_pkg::K_WS;
      sh_next     = '0;
      // bits 0-7 from reg2, 8-13 from reg1; each bit as two elements
      for (int i = 0; i < 14; i++) begin
        sh_next[53 + 2*i] = ws_word[i];
        sh_next[54 + 2*i] = !ws_word[i];
      end
      sh_next[52:0] = {vdli_pkg::WS_START, vdli_pkg::WS_RUNIN};
      nbits_next  = 7'(vdli_pkg::WS_NBITS);
      period_next = 11'(vdli_pkg::WS_ELEM_CYC);
    end
  end

  // ----------------------------------------------------------------
  // line position counter
  // ----------------------------------------------------------------
  // saturates so a stalled line timing never wraps into a false window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_cnt_reg <= 11'h000;
    end else if (line_start) begin
      line_cnt_reg <= 11'h000;
    end else if (line_cnt_reg != 11'h7ff) begin
      line_cnt_reg <= line_cnt_reg + 11'h001;
    end
  end

  // ----------------------------------------------------------------
  // insertion sequencer
  // ----------------------------------------------------------------
  // all run-in, gap and bit timing is made here, nothing from the pixel port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg  <= ST_IDLE;
      kind_reg   <= vdli_pkg::K_NONE;
      sh_reg     <= '0;
      nbits_reg  <= 7'h00;
      period_reg <= 11'h000;
      cnt_reg    <= 11'h000;
      step_reg   <= 4'h0;
    end else if (line_start) begin
      kind_reg   <= kind_next;
      sh_reg     <= sh_next;
      nbits_reg  <= nbits_next;
      period_reg <= period_next;
      cnt_reg    <= 11'h000;
      step_reg   <= 4'h0;
      state_reg  <= (kind_next == vdli_pkg::K_NONE) ? ST_IDLE : ST_DELAY;
    end else begin
      unique case (state_reg)
        ST_IDLE: ;
        ST_DELAY: begin
          if ((kind_reg == vdli_pkg::K_CC && line_cnt_reg == 11'(vdli_pkg::CC_START_CYC)) ||
              (kind_reg == vdli_pkg::K_CG && line_cnt_reg == 11'(vdli_pkg::CG_START_CYC)) ||
              (kind_reg == vdli_pkg::K_WS && line_cnt_reg == 11'(vdli_pkg::WS_START_CYC))) begin
            state_reg <= (kind_reg == vdli_pkg::K_CC) ? ST_RUNIN : ST_SHIFT;
            cnt_reg   <= 11'h000;
          end
        end
        ST_RUNIN, ST_GAP: begin
          // run-in cycle length equals one bit, so it stays phase locked
          if (cnt_reg == period_reg - 11'h001) begin
            cnt_reg  <= 11'h000;
            step_reg <= step_reg + 4'h1;
            if (state_reg == ST_RUNIN && step_reg == 4'(vdli_pkg::CC_RUNIN_CYCLES - 1)) begin
              state_reg <= ST_GAP;
              step_reg  <= 4'h0;
            end else if (state_reg == ST_GAP && step_reg == 4'(vdli_pkg::CC_GAP_BITS - 1)) begin
              state_reg <= ST_SHIFT;
            end
          end else begin
            cnt_reg <= cnt_reg + 11'h001;
          end
        end
        ST_SHIFT: begin
          // wide-screen hands the line back to video at the fixed point
          if (kind_reg == vdli_pkg::K_WS && line_cnt_reg >= 11'(vdli_pkg::WS_VIDEO_CYC - 1)) begin
            state_reg <= ST_IDLE;
          end else if (cnt_reg == period_reg - 11'h001) begin
            cnt_reg   <= 11'h000;
            sh_reg    <= sh_reg >> 1; // lsb first
            nbits_reg <= nbits_reg - 7'h01;
            if (nbits_reg == 7'h01) begin
              state_reg <= ST_IDLE;
            end
          end else begin
            cnt_reg <= cnt_reg + 11'h001;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // output level
  // ----------------------------------------------------------------
  logic [9:0] sine_lvl;
  logic [2:0] sine_idx;

  assign insert_active = (state_reg == ST_RUNIN) || (state_reg == ST_GAP) ||
                         (state_reg == ST_SHIFT);

  // eight-sample sine table around mid-level; coarse but band-limited downstream
  always_comb begin
    sine_idx = 3'((32'(cnt_reg) * 8) / (32'(period_reg) + 32'h1));
    unique case (sine_idx)
      3'h0:    sine_lvl = 10'h1c8;
      3'h1:    sine_lvl = 10'h262;
      3'h2:    sine_lvl = 10'h2a0;
      3'h3:    sine_lvl = 10'h262;
      3'h4:    sine_lvl = 10'h1c8;
      3'h5:    sine_lvl = 10'h12e;
      3'h6:    sine_lvl = 10'h0f0;
      default: sine_lvl = 10'h12e;
    endcase
  end

  // caption lines stay blank outside the burst and bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      video_out <= vdli_pkg::LVL_BLANK;
    end else if (state_reg == ST_RUNIN) begin
      video_out <= sine_lvl;
    end else if (state_reg == ST_GAP) begin
      video_out <= vdli_pkg::LVL_BLANK;
    end else if (state_reg == ST_SHIFT) begin
      video_out <= sh_reg[0] ? vdli_pkg::LVL_HIGH : vdli_pkg::LVL_BLANK;
    end else if (kind_reg == vdli_pkg::K_CC) begin
      video_out <= vdli_pkg::LVL_BLANK;
    end else begin
      video_out <= video_in;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_cc_odd_start;
    line_start && !std_pal && !field_even && line_num == vdli_pkg::CC_LINE_ODD &&
    ctrl_reg[vdli_pkg::F_CC_EN_ODD];
  endsequence
  sequence s_runin_seen;
    ##[1:A_LONG] state_reg == ST_RUNIN;
  endsequence

  property p_cc_line;
    @(posedge clk) disable iff (rst) s_cc_odd_start |-> s_runin_seen;
  endproperty
  a_cc_line: assert property (p_cc_line) else $error("caption run-in missing on line 21");

  property p_cg_ntsc;
    @(posedge clk) disable iff (rst) line_start && std_pal |=> kind_reg != vdli_pkg::K_CG;
  endproperty
  a_cg_ntsc: assert property (p_cg_ntsc) else $error("copy data outside NTSC");

  property p_ws_line;
    @(posedge clk) disable iff (rst)
      $rose(kind_reg == vdli_pkg::K_WS) |-> $past(line_num) == vdli_pkg::WS_LINE && std_pal;
  endproperty
  a_ws_line: assert property (p_ws_line) else $error("wide-screen on wrong line or standard");

  property p_ws_tail;
    @(posedge clk) disable iff (rst)
      kind_reg == vdli_pkg::K_WS && line_cnt_reg >= 11'(vdli_pkg::WS_VIDEO_CYC) |-> !insert_active;
  endproperty
  a_ws_tail: assert property (p_ws_tail) else $error("wide-screen past video point");

  property p_cc_blank;
    @(posedge clk) disable iff (rst)
      kind_reg == vdli_pkg::K_CC && state_reg == ST_IDLE && !line_start
      |=> video_out == vdli_pkg::LVL_BLANK;
  endproperty
  a_cc_blank: assert property (p_cc_blank) else $error("pixel data leaked on caption line");

  property p_start_bit;
    @(posedge clk) disable iff (rst)
      kind_reg == vdli_pkg::K_CC && state_reg == ST_GAP ##1 state_reg == ST_SHIFT |-> sh_reg[0];
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("caption start bit not one");

  property p_crc;
    @(posedge clk) disable iff (rst)
      cw0_reg[vdli_pkg::F_CRC_AUTO] |-> cg_word[19:14] == vdli_crc(cg_word[13:0]) &&
      cg_word[13:0] == {cw1_reg[5:0], cw2_reg};
  endproperty
  a_crc: assert property (p_crc) else $error("copy check bits wrong");

  property p_snap;
    @(posedge clk) disable iff (rst)
      line_start && kind_next == vdli_pkg::K_CG |=> sh_reg[20:1] == $past(cg_word);
  endproperty
  a_snap: assert property (p_snap) else $error("copy word not captured at line start");

  property p_unmapped;
    @(posedge clk) disable iff (rst) rd && addr > vdli_pkg::A_STAT |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

endmodule : vdli_inserter

`default_nettype wire

// ===== vdli_host_model.sv
// Purpose: host processor model that loads the inserter payload registers
// Assumes: single clock, register port with one-cycle strobes
// Notes:   every signal changes by non-blocking assignment just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module vdli_host_model (
  // clock
  input  wire logic       clk,
  // register port
  output var  logic [7:0] addr,
  output var  logic [7:0] wdata,
  output var  logic       wr,
  output var  logic       rd,
  input  wire logic [7:0] rdata
);
  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // quiet bus from time zero so nothing is taken during reset
  initial begin
    addr  = 8'h00;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // one-cycle write; data is inverted afterwards so a stale value is never reused
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    wdata <= ~d;
  endtask : write_reg

  // one-cycle read; data stands only in the following cycle
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : read_reg

  // both bytes of a pair are written together, ahead of the caption line
  task automatic load_caption(input logic [7:0] a, input logic [7:0] b0, input logic [7:0] b1);
    write_reg(a, b0);
    write_reg(a + 8'h04, b1);
  endtask : load_caption

  // nothing new for this field: both bytes go to zero
  task automatic null_fill(input logic [7:0] a);
    load_caption(a, 8'h00, 8'h00);
  endtask : null_fill
endmodule : vdli_host_model
`default_nettype wire

// ===== vdli_inserter_bench.sv
// Purpose: self-checking bench for the blanking data line inserter
// Assumes: 20 MHz clock, line_start pulses driven by the bench
// Notes:   bit levels are sampled mid-period so one cycle of skew is tolerated
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module vdli_inserter_bench;
  // ----------------------------------------------------------------
  // signals and helpers
  // ----------------------------------------------------------------
  localparam int TIMEOUT_CYC = 30000;
  localparam int LINE_CYC    = 1300;
  logic        clk          = 1'b0;
  logic        rst          = 1'b1;
  logic        line_start   = 1'b0;
  logic [9:0]  line_num     = 10'h000;
  logic        field_even   = 1'b0;
  logic [9:0]  video_in     = 10'h000;
  logic [9:0]  video_out;
  logic        insert_active;
  logic [7:0]  addr, wdata, rdata, rv, b0, b1;
  logic        wr, rd;
  logic [31:0] seed         = 32'hbd0232a9;
  logic [31:0] r;
  logic [19:0] word;
  int          mismatches   = 0;
  int          total_checks = 0;
  int          cycle_count  = 0;

  // clock generator
  always #25 clk = ~clk;

  vdli_inserter dut_u (.clk(clk), .rst(rst), .line_start(line_start), .line_num(line_num),
    .field_even(field_even), .video_in(video_in), .video_out(video_out), .insert_active(insert_active),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  vdli_host_model host_u (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

  // xorshift keeps the run repeatable from a fixed seed
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // seven data bits plus a parity bit that makes the byte odd
  function automatic logic [7:0] cc_byte(input logic [31:0] d);
    return {~^d[6:0], d[6:0]};
  endfunction : cc_byte

  // check bits over C0..C13 in send order, preset all ones
  function automatic logic [19:0] cg_word(input logic [19:0] w, input logic auto);
    logic [5:0] c;
    logic       fb;
    c = 6'h3f;
    for (int i = 0; i < 14; i++) begin
      fb = c[5] ^ w[i];
      c  = {c[4:0], 1'b0} ^ {4'h0, fb, fb};
    end
    return auto ? {c, w[13:0]} : w;
  endfunction : cg_word

  // run-in, start code, then each bit followed by its inverse
  function automatic logic [95:0] ws_bits(input logic [13:0] w);
    logic [95:0] v;
    v        = 96'h0;
    v[28:0]  = vdli_pkg::WS_RUNIN;
    v[52:29] = vdli_pkg::WS_START;
    for (int i = 0; i < 14; i++) begin
      v[53 + 2 * i] = w[i];
      v[54 + 2 * i] = ~w[i];
    end
    return v;
  endfunction : ws_bits

  // one line: n == 0 means nothing may be inserted; kind 1 marks a caption line
  task automatic run_line(input logic [9:0] ln, input logic ev, input int kind, input int t0,
                          input int per, input int n, input logic [95:0] bits);
    logic [9:0] vin;
    r   = rnd();
    vin = {1'b1, r[8:0]};
    @(posedge clk);
    line_num   <= ln;
    field_even <= ev;
    video_in   <= vin;
    line_start <= 1'b1;
    @(posedge clk);
    line_start <= 1'b0;
    for (int c = 1; c <= LINE_CYC; c++) begin
      @(posedge clk);
      #1;
      if (n > 0 && c >= t0 && (c - t0) % per == per / 2 && (c - t0) / per < n)
        `CHK(video_out, bits[(c - t0) / per] ? vdli_pkg::LVL_HIGH : vdli_pkg::LVL_BLANK)
      if (kind == 1 && c == 100) `CHK(video_out, vdli_pkg::LVL_BLANK)
      if (kind == 1 && c == 205) `CHK(insert_active, 1'b0)
      if (kind == 1 && c == 215) `CHK(insert_active, 1'b1)
      if (kind == 1 && c == 520) `CHK(video_out, vdli_pkg::LVL_BLANK)
      if (n == 0 && c == 600) `CHK(insert_active, 1'b0)
      if (kind != 1 && c == 1290) `CHK(video_out, vin)
    end
  endtask : run_line

  // verdict and end of run, reached from the main sequence or the timeout
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // a hang counts as a mismatch
  always @(posedge clk) begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == TIMEOUT_CYC) begin
      mismatches++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    host_u.read_reg(vdli_pkg::A_CTRL, rv);
    `CHK(rv, 8'h00)
    r = rnd();
    host_u.write_reg(vdli_pkg::A_CW1, r[7:0]);
    host_u.read_reg(vdli_pkg::A_CW1, rv);
    `CHK(rv, r[7:0])
    host_u.write_reg(vdli_pkg::A_STAT, 8'hff);
    host_u.read_reg(vdli_pkg::A_STAT, rv);
    `CHK(rv, 8'h00)
    host_u.read_reg(8'hfc, rv);
    `CHK(rv, 8'h00)
    $display("test registers done");
    b0 = cc_byte(rnd());
    b1 = cc_byte(rnd());
    host_u.load_caption(vdli_pkg::A_CC0, b0, b1);
    host_u.write_reg(vdli_pkg::A_CTRL, 8'h03);
    // a write in mid-line must wait for the next caption line
    fork
      run_line(vdli_pkg::CC_LINE_ODD, 1'b0, 1, 563, 39, 17, {79'h0, b1, b0, 1'b1});
      begin
        repeat (300) @(posedge clk);
        host_u.write_reg(vdli_pkg::A_CC0, 8'h80);
      end
    join
    run_line(vdli_pkg::CC_LINE_ODD, 1'b0, 1, 563, 39, 17, {79'h0, b1, 8'h80, 1'b1});
    b0 = cc_byte(rnd());
    b1 = cc_byte(rnd());
    host_u.load_caption(vdli_pkg::A_CCX0, b0, b1);
    run_line(vdli_pkg::CC_LINE_EVEN, 1'b1, 1, 563, 39, 17, {79'h0, b1, b0, 1'b1});
    host_u.null_fill(vdli_pkg::A_CCX0);
    run_line(vdli_pkg::CC_LINE_EVEN, 1'b1, 1, 563, 39, 17, {95'h0, 1'b1});
    $display("test caption done");
    host_u.write_reg(vdli_pkg::A_CTRL, 8'h00);
    for (int a = 0; a < 2; a++) begin
      r    = rnd();
      word = r[19:0];
      host_u.write_reg(vdli_pkg::A_CW0, {3'b001, a[0], word[19:16]});
      host_u.write_reg(vdli_pkg::A_CW1, word[15:8]);
      host_u.write_reg(vdli_pkg::A_CW2, word[7:0]);
      run_line(vdli_pkg::CG_LINE_ODD, 1'b0, 2, 226, 44, 21, {75'h0, cg_word(word, a[0]), 1'b1});
    end
    run_line(vdli_pkg::CG_LINE_EVEN, 1'b1, 2, 0, 1, 0, 96'h0);
    host_u.write_reg(vdli_pkg::A_CW0, {4'h5, word[19:16]});
    run_line(vdli_pkg::CG_LINE_EVEN, 1'b1, 2, 226, 44, 21, {75'h0, cg_word(word, 1'b1), 1'b1});
    host_u.write_reg(vdli_pkg::A_CTRL, 8'h04);
    host_u.write_reg(vdli_pkg::A_CW0, 8'h60);
    run_line(vdli_pkg::CG_LINE_ODD, 1'b0, 2, 0, 1, 0, 96'h0);
    $display("test copy done");
    r  = rnd();
    b0 = r[7:0];
    b1 = r[15:8];
    host_u.write_reg(vdli_pkg::A_CW0, 8'h80);
    host_u.write_reg(vdli_pkg::A_CW1, b1);
    host_u.write_reg(vdli_pkg::A_CW2, b0);
    run_line(vdli_pkg::WS_LINE, 1'b0, 3, 222, 4, 81, ws_bits({b1[5:0], b0}));
    run_line(10'h018, 1'b0, 3, 0, 1, 0, 96'h0);
    host_u.write_reg(vdli_pkg::A_CTRL, 8'h00);
    run_line(vdli_pkg::WS_LINE, 1'b0, 3, 0, 1, 0, 96'h0);
    host_u.write_reg(vdli_pkg::A_CTRL, 8'h04);
    host_u.write_reg(vdli_pkg::A_CW0, 8'h00);
    run_line(vdli_pkg::WS_LINE, 1'b0, 3, 0, 1, 0, 96'h0);
    $display("test widescreen done");
    stop_test();
  end
endmodule : vdli_inserter_bench
`default_nettype wire
